// [hdl/smt_sequencer.sv]
// transfer sequencer of a memory-card host controller, APB register slave
//
// Behaviour
// - program-done flag raised when card releases busy after write
// - card clock halts while receive FIFO is full
// - read pause: begin, status set when entered, end on request
// - response end, data done, program done as masked flags
`timescale 1ns/1ps
module smt_sequencer #(
  parameter int CLK_DIV  = 2,  // mclk cycles per card clock half period
  parameter int RX_DEPTH = 4,  // receive FIFO entries
  parameter int TX_DEPTH = 4   // transmit FIFO entries
) (
  input  wire logic        mclk,        // 40 MHz system clock
  input  wire logic        sys_rst,     // synchronous reset, active high
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error on unmapped address
  output logic             irq,         // masked interrupt, active high
  input  wire logic        cardDat0,    // card data line 0 pin, low = busy
  output logic             cardClock,   // card clock to the card
  output logic             phyStart,    // pulse: begin command on link
  output smt_pkg::smt_cmdat_t phyAttr,  // attributes of current command
  input  wire logic        phyRespEnd,  // pulse: response received
  input  wire logic        phyBlockEnd, // pulse: one block moved
  input  wire logic        phyRxValid,  // receive word offered
  input  wire logic [31:0] phyRxData,   // receive word
  output logic             phyTxValid,  // transmit word available
  input  wire logic        phyTxReady,  // link takes transmit word
  output logic      [31:0] phyTxData    // transmit word
);
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  smt_pkg::smt_cmdat_t cmdAttr;
  smt_pkg::smt_state_t state;
  logic [15:0] blockCount;
  logic [15:0] doneCount;
  logic [smt_pkg::IRQ_BITS-1:0] iflag;
  logic [smt_pkg::IRQ_BITS-1:0] imask;
  logic        clkReq;
  logic        clkRun;
  logic        exitReq;
  logic        busyCmd;
  logic [15:0] divCount;
  logic        dat0Meta;
  logic        dat0Sync;
  logic [31:0] rxMem [RX_DEPTH];
  logic [31:0] txMem [TX_DEPTH];
  logic [$clog2(RX_DEPTH):0] rxCount;
  logic [$clog2(TX_DEPTH):0] txCount;
  logic [$clog2(RX_DEPTH)-1:0] rxHead;
  logic [$clog2(RX_DEPTH)-1:0] rxTail;
  logic [$clog2(TX_DEPTH)-1:0] txHead;
  logic [$clog2(TX_DEPTH)-1:0] txTail;
  logic        wrAcc;
  logic        rdAcc;
  logic [31:0] ctlPulse;
  logic        rxFull;
  logic        txFull;
  logic        rxPush;
  logic        rxPop;
  logic        txPush;
  logic        txPop;
  logic        cardGated;
  logic        dataDone;
  logic        progDone;
  logic [smt_pkg::IRQ_BITS-1:0] irqSet;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= smt_pkg::OFS_RXPORT);
  endfunction : mapped

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign wrAcc    = psel && penable && pwrite && mapped(paddr);
  assign rdAcc    = psel && penable && !pwrite && mapped(paddr);
  assign ctlPulse = (wrAcc && hit(paddr, smt_pkg::OFS_CTRL)) ? pwdata
                                                               : 32'h0;

  always_comb begin
    prdata = 32'h0;
    if (!psel || pwrite) begin
      prdata = 32'h0;
    end else if (hit(paddr, smt_pkg::OFS_STAT)) begin
      prdata[smt_pkg::ST_RX_FULL]   = rxFull;
      prdata[smt_pkg::ST_RX_EMPTY]  = (rxCount == '0);
      prdata[smt_pkg::ST_TX_FULL]   = txFull;
      prdata[smt_pkg::ST_CLK_EN]    = clkRun;
      prdata[smt_pkg::ST_PAUSE]     = (state == smt_pkg::SQ_PAUSE);
      prdata[smt_pkg::ST_CARD_BUSY] = !dat0Sync;
      prdata[smt_pkg::ST_ACTIVE]    = (state != smt_pkg::SQ_IDLE);
    end else if (hit(paddr, smt_pkg::OFS_CMDAT)) begin
      prdata[smt_pkg::CMDAT_BITS-1:0] = cmdAttr;
    end else if (hit(paddr, smt_pkg::OFS_NBLK)) begin
      prdata[15:0] = blockCount;
    end else if (hit(paddr, smt_pkg::OFS_DONE)) begin
      prdata[15:0] = doneCount;
    end else if (hit(paddr, smt_pkg::OFS_IFLAG)) begin
      prdata[smt_pkg::IRQ_BITS-1:0] = iflag;
    end else if (hit(paddr, smt_pkg::OFS_IMASK)) begin
      prdata[smt_pkg::IRQ_BITS-1:0] = imask;
    end else if (hit(paddr, smt_pkg::OFS_RXPORT)) begin
      prdata = rxMem[rxHead];
    end
  end

  // ----------------------------------------------------------------
  // software-written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdAttr    <= '0;
      blockCount <= smt_pkg::NBLK_RESET;
      imask      <= smt_pkg::IMASK_RESET;
    end else if (wrAcc) begin
      if (hit(paddr, smt_pkg::OFS_CMDAT)) begin
        cmdAttr <= pwdata[smt_pkg::CMDAT_BITS-1:0];
      end else if (hit(paddr, smt_pkg::OFS_NBLK)) begin
        blockCount <= pwdata[15:0];
      end else if (hit(paddr, smt_pkg::OFS_IMASK)) begin
        imask <= pwdata[smt_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // busy pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dat0Meta <= 1'b1;
      dat0Sync <= 1'b1;
    end else begin
      dat0Meta <= cardDat0;
      dat0Sync <= dat0Meta;
    end
  end

  // ----------------------------------------------------------------
  // card clock
  // ----------------------------------------------------------------
  // the clock only stops or restarts while low, so no runt pulse
  assign cardGated = !clkReq || rxFull;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clkReq <= 1'b1;
    end else if (ctlPulse[smt_pkg::CTL_CLK_STOP]) begin
      clkReq <= 1'b0;
    end else if (ctlPulse[smt_pkg::CTL_CLK_START]) begin
      clkReq <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      divCount  <= '0;
      cardClock <= 1'b0;
      clkRun    <= 1'b1;
    end else if (!cardClock && cardGated) begin
      divCount <= '0;
      clkRun   <= clkReq;
    end else if (divCount == 16'(CLK_DIV - 1)) begin
      divCount  <= '0;
      cardClock <= !cardClock;
      clkRun    <= 1'b1;
    end else begin
      divCount <= divCount + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // data FIFOs
  // ----------------------------------------------------------------
  assign rxFull     = (rxCount == ($clog2(RX_DEPTH)+1)'(RX_DEPTH));
  assign txFull     = (txCount == ($clog2(TX_DEPTH)+1)'(TX_DEPTH));
  assign rxPush     = phyRxValid && !rxFull && (state == smt_pkg::SQ_DATA);
  assign rxPop      = rdAcc && hit(paddr, smt_pkg::OFS_RXPORT)
                      && (rxCount != '0);
  assign txPush     = wrAcc && hit(paddr, smt_pkg::OFS_TXPORT) && !txFull;
  assign phyTxValid = (txCount != '0);
  assign txPop      = phyTxValid && phyTxReady;
  assign phyTxData  = txMem[txHead];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxHead  <= '0;
      rxTail  <= '0;
      rxCount <= '0;
    end else begin
      if (rxPush) begin
        rxMem[rxTail] <= phyRxData;
        rxTail <= rxTail + 1'b1;
      end
      if (rxPop) begin
        rxHead <= rxHead + 1'b1;
      end
      rxCount <= rxCount + ($bits(rxCount))'(rxPush)
                 - ($bits(rxCount))'(rxPop);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txHead  <= '0;
      txTail  <= '0;
      txCount <= '0;
    end else begin
      if (txPush) begin
        txMem[txTail] <= pwdata;
        txTail <= txTail + 1'b1;
      end
      if (txPop) begin
        txHead <= txHead + 1'b1;
      end
      txCount <= txCount + ($bits(txCount))'(txPush)
                 - ($bits(txCount))'(txPop);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // counted blocks end unless open-ended (zero count) or streaming
  assign dataDone = (state inside {smt_pkg::SQ_DATA, smt_pkg::SQ_PAUSE})
    && (exitReq || (phyBlockEnd && !cmdAttr.streamMode
        && blockCount != 16'h0
        && doneCount + 16'h1 == blockCount));
  assign progDone = (state == smt_pkg::SQ_BUSY) && dat0Sync;
  assign phyAttr  = cmdAttr;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exitReq <= 1'b0;
    end else if (state == smt_pkg::SQ_IDLE || dataDone) begin
      exitReq <= 1'b0;
    end else if (ctlPulse[smt_pkg::CTL_EXIT_MULTI]
                 || ctlPulse[smt_pkg::CTL_EXIT_XFER]) begin
      exitReq <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state     <= smt_pkg::SQ_IDLE;
      phyStart  <= 1'b0;
      doneCount <= '0;
      busyCmd   <= 1'b0;
    end else begin
      phyStart <= 1'b0;
      case (state)
        smt_pkg::SQ_IDLE: begin
          if (ctlPulse[smt_pkg::CTL_START_OP]) begin
            phyStart  <= 1'b1;
            doneCount <= '0;
            busyCmd   <= cmdAttr.busyExp;
            state     <= smt_pkg::SQ_CMD;
          end
        end
        smt_pkg::SQ_CMD: begin
          if (phyRespEnd) begin
            if (cmdAttr.dataEn) begin
              state <= smt_pkg::SQ_DATA;
            end else if (busyCmd) begin
              state <= smt_pkg::SQ_BUSY;
            end else begin
              state <= smt_pkg::SQ_IDLE;
            end
          end
        end
        smt_pkg::SQ_DATA: begin
          if (phyBlockEnd) begin
            doneCount <= doneCount + 16'h1;
          end
          if (dataDone) begin
            state <= cmdAttr.writeDir ? smt_pkg::SQ_BUSY
                                      : smt_pkg::SQ_IDLE;
          end else if (ctlPulse[smt_pkg::CTL_PAUSE_ON]
                       && !cmdAttr.writeDir) begin
            state <= smt_pkg::SQ_PAUSE;
          end
        end
        smt_pkg::SQ_PAUSE: begin
          if (dataDone) begin
            state <= smt_pkg::SQ_IDLE;
          end else if (ctlPulse[smt_pkg::CTL_PAUSE_OFF]) begin
            state <= smt_pkg::SQ_DATA;
          end
        end
        smt_pkg::SQ_BUSY: begin
          if (dat0Sync) begin
            state <= smt_pkg::SQ_IDLE;
          end
        end
        default: begin
          state <= smt_pkg::SQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags: write 1 clears, a new event wins over the clear
  // ----------------------------------------------------------------
  always_comb begin
    irqSet = '0;
    irqSet[smt_pkg::IRQ_DATA_DONE] = dataDone;
    irqSet[smt_pkg::IRQ_PROG_DONE] = progDone;
    irqSet[smt_pkg::IRQ_RESP_END]  = (state == smt_pkg::SQ_CMD)
                                     && phyRespEnd;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      iflag <= '0;
    end else if (wrAcc && hit(paddr, smt_pkg::OFS_IFLAG)) begin
      iflag <= (iflag & ~pwdata[smt_pkg::IRQ_BITS-1:0]) | irqSet;
    end else begin
      iflag <= iflag | irqSet;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(iflag & imask);
    end
  end
endmodule : smt_sequencer

// [pkg/smt_pkg.sv]
// package: register map, field layout and types of the transfer sequencer
package smt_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // start_stop_control_reg
  localparam logic [7:0] OFS_STAT   = 8'h04; // controller_status_reg
  localparam logic [7:0] OFS_CMDAT  = 8'h08; // command_attribute_reg
  localparam logic [7:0] OFS_NBLK   = 8'h0c; // block_count_reg
  localparam logic [7:0] OFS_DONE   = 8'h10; // completed_block_count
  localparam logic [7:0] OFS_IFLAG  = 8'h14; // interrupt_flag_reg
  localparam logic [7:0] OFS_IMASK  = 8'h18; // interrupt_mask_reg
  localparam logic [7:0] OFS_TXPORT = 8'h1c; // transmit_fifo_port
  localparam logic [7:0] OFS_RXPORT = 8'h20; // receive_fifo_port
  // ----------------------------------------------------------------
  // start_stop_control_reg bits (write 1 for a one-shot action)
  // ----------------------------------------------------------------
  localparam int CTL_CLK_STOP   = 0;
  localparam int CTL_CLK_START  = 1;
  localparam int CTL_START_OP   = 2;
  localparam int CTL_EXIT_MULTI = 3;
  localparam int CTL_EXIT_XFER  = 4;
  localparam int CTL_PAUSE_ON   = 5;
  localparam int CTL_PAUSE_OFF  = 6;
  // ----------------------------------------------------------------
  // controller_status_reg bits
  // ----------------------------------------------------------------
  localparam int ST_RX_FULL   = 0;
  localparam int ST_RX_EMPTY  = 1;
  localparam int ST_TX_FULL   = 2;
  localparam int ST_CLK_EN    = 3;
  localparam int ST_PAUSE     = 4;
  localparam int ST_CARD_BUSY = 5;
  localparam int ST_ACTIVE    = 6;
  // ----------------------------------------------------------------
  // interrupt flag / mask bits
  // ----------------------------------------------------------------
  localparam int IRQ_DATA_DONE = 0;
  localparam int IRQ_PROG_DONE = 1;
  localparam int IRQ_RESP_END  = 2;
  localparam int IRQ_BITS      = 3;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] NBLK_RESET  = 16'h0000;
  localparam logic [2:0]  IMASK_RESET = 3'h0;
  localparam int          CMDAT_BITS  = 11;
  // command attributes as laid out in command_attribute_reg
  typedef struct packed {
    logic       ioAbort;    // [10]
    logic       initSeq;    // [9]
    logic       busyExp;    // [8]
    logic       streamMode; // [7]
    logic       writeDir;   // [6]
    logic       dataEn;     // [5]
    logic [1:0] busWidth;   // [4:3]
    logic [2:0] respFmt;    // [2:0]
  } smt_cmdat_t;
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_CMD   = 3'b001,
    SQ_DATA  = 3'b010,
    SQ_PAUSE = 3'b011,
    SQ_BUSY  = 3'b100
  } smt_state_t;
endpackage : smt_pkg

// [testbench/smt_card_model.sv]
// card-side model: response, blocks, receive words, busy on dat0
`timescale 1ns/1ps
module smt_card_model #(
  parameter int BUSY_LEN = 60 // cycles the card stays busy
) (
  input  wire logic        mclk,        // system clock
  input  wire logic        phyStart,    // command start
  input  smt_pkg::smt_cmdat_t phyAttr,  // command attributes
  input  wire logic        phyTxValid,  // tx word available
  input  wire logic [31:0] phyTxData,   // tx word
  input  wire logic        txGo,        // bench lets words flow
  input  wire logic [31:0] blocks,      // blocks to move
  input  wire logic [31:0] rxWords,     // rx words to offer
  output logic             phyRespEnd,  // response pulse
  output logic             phyBlockEnd, // block pulse
  output logic             phyRxValid,  // rx word offered
  output logic      [31:0] phyRxData,   // rx word
  output logic             phyTxReady,  // tx pop
  output logic             cardDat0,    // dat0, pulled up
  output int               txCount,     // tx words taken
  output logic      [31:0] txLast       // last tx word
);
  int cnt, ph, left, wl;
  assign phyTxReady = txGo;
  initial begin
    {phyRespEnd, phyBlockEnd, phyRxValid} = 3'h0;
    phyRxData = 32'h0; cardDat0 = 1'b1; txCount = 0; txLast = 32'h0;
    cnt = 0; ph = 0; left = 0; wl = 0;
  end
  always @(posedge mclk) begin
    phyRespEnd <= 1'b0; phyBlockEnd <= 1'b0; phyRxValid <= 1'b0;
    phyRxData <= ~phyRxData;
    if (phyTxValid && txGo) begin
      txCount <= txCount + 1; txLast <= phyTxData;
    end
    if (phyStart) begin
      cnt <= 5; ph <= 1;
      if (phyAttr.busyExp || phyAttr.writeDir) cardDat0 <= 1'b0;
    end else if (cnt > 0) cnt <= cnt - 1;
    else case (ph)
      1: begin
        phyRespEnd <= 1'b1; left <= blocks; wl <= rxWords; cnt <= BUSY_LEN;
        ph <= phyAttr.dataEn ? 2 : (phyAttr.busyExp ? 3 : 0);
      end
      2: if (wl > 0) begin
        phyRxValid <= 1'b1; phyRxData <= 32'h5a5a0000 | wl; wl <= wl - 1;
      end else if (left > 0) begin
        phyBlockEnd <= 1'b1; left <= left - 1; cnt <= 4;
      end else begin
        ph <= phyAttr.writeDir ? 3 : 0; cnt <= BUSY_LEN;
      end
      3: begin cardDat0 <= 1'b1; ph <= 0; end
      default: ph <= 0;
    endcase
  end
endmodule : smt_card_model

// [testbench/smt_properties.sv]
// checker: port-level assertions of the transfer sequencer
`timescale 1ns/1ps
module smt_properties #(
  parameter int CLK_DIV = 2 // card clock half period
) (
  input wire logic        mclk,      // system clock
  input wire logic        sys_rst,   // synchronous reset
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb access phase
  input wire logic        pwrite,    // apb direction
  input wire logic [7:0]  paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb write data
  input wire logic [31:0] prdata,    // apb read data
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic        irq,       // masked interrupt
  input wire logic        cardClock, // card clock
  input wire logic        phyStart,  // command start pulse
  input smt_pkg::smt_cmdat_t phyAttr // command attributes
);
  logic [7:0] hiCnt;
  logic       acc;
  logic       badA;
  assign acc  = psel && penable;
  assign badA = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
  // ----------------------------------------------------------------
  // helper: length of the current high phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || !cardClock) hiCnt <= 8'h00;
    else hiCnt <= hiCnt + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_clk_high: assert property ($fell(cardClock) |-> hiCnt == CLK_DIV)
    else $error("card clock high phase length wrong");
  chk_clk_low: assert property (
    $rose(cardClock) |-> $past(cardClock, CLK_DIV) == 1'b0)
    else $error("card clock low phase too short");
  chk_start_pulse: assert property (phyStart |=> !phyStart)
    else $error("start pulse longer than one cycle");
  chk_attr_write: assert property (
    acc && pwrite && paddr == smt_pkg::OFS_CMDAT
    |=> phyAttr == $past(pwdata[10:0]))
    else $error("attributes not taken from write");
  chk_attr_read: assert property (
    acc && !pwrite && paddr == smt_pkg::OFS_CMDAT
    |-> prdata == {21'h0, phyAttr})
    else $error("attribute readback wrong");
  chk_bad_addr: assert property (acc && badA |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (acc && !badA |-> !pslverr)
    else $error("mapped access refused");
  chk_ctrl_read: assert property (
    acc && !pwrite && paddr == smt_pkg::OFS_CTRL |-> prdata == 32'h0)
    else $error("control register reads nonzero");
  chk_mask_off: assert property (
    acc && pwrite && paddr == smt_pkg::OFS_IMASK && pwdata[2:0] == 3'h0
    |-> ##2 !irq)
    else $error("irq high with all sources masked");
  cov_start: cover property (phyStart);
  cov_clk: cover property ($fell(cardClock));
  cov_err: cover property (pslverr);
endmodule : smt_properties
bind smt_sequencer smt_properties #(.CLK_DIV(CLK_DIV)) chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .cardClock(cardClock),
  .phyStart(phyStart), .phyAttr(phyAttr));

// [testbench/tb.sv]
// testbench: register table, block and stream transfers, clock gating
`timescale 1ns/1ps
module tb;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, e, m; logic r;}
    smt_row_t;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, txGo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, phyRxData, phyTxData, txLast;
  logic cardDat0, cardClock, phyStart, phyRespEnd, phyBlockEnd, phyRxValid;
  logic phyTxValid, phyTxReady, er, lo;
  smt_pkg::smt_cmdat_t phyAttr;
  int bad_count, num_checks, blocks, rxWords, txCount, n;
  smt_row_t rows[13] = '{
    '{0, 8'h04, 0, 32'h0a, 32'h7f, 0}, '{0, 8'h0c, 0, 0, 32'hffff, 0},
    '{0, 8'h18, 0, 0, 32'h7, 0}, '{0, 8'h14, 0, 0, 32'h7, 0},
    '{0, 8'h10, 0, 0, 32'hffff, 0}, '{0, 8'h00, 0, 0, 32'hffffffff, 0},
    '{1, 8'h0c, 32'h1234, 0, 0, 0}, '{0, 8'h0c, 0, 32'h1234, 32'hffff, 0},
    '{1, 8'h08, 32'h7ff, 0, 0, 0}, '{0, 8'h08, 0, 32'h7ff, 32'h7ff, 0},
    '{0, 8'h24, 0, 0, 32'hffffffff, 1}, '{0, 8'h06, 0, 0, 32'hffffffff, 1},
    '{1, 8'h40, 32'h1, 0, 0, 1}};
  smt_sequencer #(.CLK_DIV(4)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cardDat0(cardDat0), .cardClock(cardClock),
    .phyStart(phyStart), .phyAttr(phyAttr), .phyRespEnd(phyRespEnd),
    .phyBlockEnd(phyBlockEnd), .phyRxValid(phyRxValid),
    .phyRxData(phyRxData), .phyTxValid(phyTxValid),
    .phyTxReady(phyTxReady), .phyTxData(phyTxData));
  smt_card_model card_u (.mclk(mclk), .phyStart(phyStart),
    .phyAttr(phyAttr), .phyTxValid(phyTxValid), .phyTxData(phyTxData),
    .txGo(txGo), .blocks(blocks), .rxWords(rxWords),
    .phyRespEnd(phyRespEnd), .phyBlockEnd(phyBlockEnd),
    .phyRxValid(phyRxValid), .phyRxData(phyRxData),
    .phyTxReady(phyTxReady), .cardDat0(cardDat0), .txCount(txCount),
    .txLast(txLast));
  always #12.5 mclk = ~mclk;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdc
  // poll a status or flag bit until it reaches the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    n = 0;
    do begin apb(1'b0, a, 32'h0); n++; end while (rd[b] !== v && n < 300);
    chk("poll", {31'h0, v}, {31'h0, rd[b]});
  endtask : poll
  initial begin
    mclk = 0; sys_rst = 1; {psel, penable, pwrite, txGo} = 4'h0;
    paddr = 8'h00; pwdata = 32'h0; blocks = 0; rxWords = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("rdata", rows[i].e, rd & rows[i].m);
      chk("pslverr", {31'h0, rows[i].r}, {31'h0, er});
    end
    // predefined two-block read, no stop command
    blocks <= 2; apb(1, 8'h0c, 32'h2); apb(1, 8'h08, 32'h021);
    apb(1, 8'h18, 32'h7); apb(1, 8'h00, 32'h4);
    poll(8'h14, 0, 1'b1);
    rdc("done", 8'h10, 32'hffff, 32'h2);
    rdc("flags", 8'h14, 32'h7, 32'h5);
    chk("irq", 1, irq);
    apb(1, 8'h14, 32'h7); repeat (3) @(posedge mclk);
    chk("irq clr", 0, irq);
    // open-ended read ended early, masked, then busy stop command
    blocks <= 10; apb(1, 8'h18, 32'h0); apb(1, 8'h0c, 32'h0);
    apb(1, 8'h00, 32'h4); poll(8'h10, 0, 1'b1);
    apb(1, 8'h00, 32'h8); poll(8'h14, 0, 1'b1);
    apb(1'b0, 8'h10, 32'h0); chk("early", 1, rd < 10);
    n = 10 - rd; apb(1, 8'h0c, n);
    rdc("resume", 8'h0c, 32'hffff, n);
    apb(1, 8'h08, 32'h401); rdc("abort", 8'h08, 32'h400, 32'h400);
    chk("irq masked", 0, irq);
    apb(1, 8'h14, 32'h7); apb(1, 8'h08, 32'h101); apb(1, 8'h00, 32'h4);
    poll(8'h14, 2, 1'b1);
    rdc("busy", 8'h14, 32'h2, 32'h0);
    rdc("busy st", 8'h04, 32'h20, 32'h20);
    poll(8'h14, 1, 1'b1);
    // stream read: full rx fifo halts card clock
    apb(1, 8'h14, 32'h7); blocks <= 0; rxWords <= 6;
    apb(1, 8'h08, 32'h0a1); apb(1, 8'h00, 32'h4);
    poll(8'h04, 0, 1'b1); repeat (8) @(posedge mclk);
    lo = 0; repeat (12) begin @(posedge mclk); lo = lo | cardClock; end
    chk("rx halt", 0, lo);
    rdc("clk en", 8'h04, 32'h8, 32'h8);
    apb(1, 8'h00, 32'h20); rdc("pause", 8'h04, 32'h10, 32'h10);
    apb(1, 8'h00, 32'h40); rdc("unpause", 8'h04, 32'h10, 32'h0);
    apb(1, 8'h00, 32'h10);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'h20, 32'h0); chk("rx", 32'h5a5a0006 - i, rd);
    end
    poll(8'h14, 0, 1'b1);
    rdc("rx empty", 8'h04, 32'h3, 32'h2);
    // stream write: tx fills and refuses, then busy until programmed
    apb(1, 8'h14, 32'h7); rxWords <= 0; apb(1, 8'h08, 32'h0e1);
    for (int i = 0; i < 5; i++) apb(1, 8'h1c, 32'hd0 + i);
    rdc("tx full", 8'h04, 32'h4, 32'h4);
    apb(1, 8'h00, 32'h4); txGo <= 1'b1; poll(8'h14, 2, 1'b1);
    repeat (20) @(posedge mclk);
    chk("tx cnt", 4, txCount);
    chk("tx last", 32'hd3, txLast);
    apb(1, 8'h00, 32'h10); poll(8'h14, 0, 1'b1);
    poll(8'h14, 1, 1'b1);
    // clock stop and restart
    apb(1, 8'h00, 32'h1); poll(8'h04, 3, 1'b0);
    lo = 0; repeat (12) begin @(posedge mclk); lo = lo | cardClock; end
    chk("clk off", 0, lo);
    apb(1, 8'h00, 32'h2); poll(8'h04, 3, 1'b1);
    // reset in mid-run
    apb(1, 8'h0c, 32'h5); @(posedge mclk); sys_rst <= 1'b1;
    @(posedge mclk); sys_rst <= 1'b0;
    rdc("nblk rst", 8'h0c, 32'hffff, 32'h0);
    results();
  end
  initial begin
    #(25 * 40000);
    bad_count++;
    results();
  end
endmodule : tb
